// File: hw/cfa_core.sv
`timescale 1ns/100ps
// How it works
// - Flag register is 8 bits; bits 6 and 5 always read one.
// - Bit 7 flags two's complement overflow; signed branches test it.
// - Bit 4 records carry from bit 3 into bit 4 on adds.
// - Decimal adjust uses half-carry and carry to correct a BCD sum.
// - Bit 3 set blocks maskable interrupts; clear accepts them.
// - Interrupt entry sets the mask after stacking, before the handler.
// - No interrupt at the boundary right after the mask is cleared.
// - Bit 2 follows the result's top bit, loads included; moves leave it.
// - Bit 1 set when the 8- or 16-bit result is all zero.
// - Bit 0 is carry or borrow; bit tests and shifts also set it.
// - One 16-bit address reaches memory, registers and ports alike.
// - Move takes its source by one mode, its destination by another.
// - Immediate test-and-branch fetches the tested operand, then a relative target; the register form fetches only the target.
// - Register operand mode makes no memory access.
// - Relative offset byte follows opcode, sign-extended, added to counter.
// - Inline 16-bit operand: high byte first, low byte next.
// - Program counter steps per fetched byte except on change of flow.
module cfa_core
    import cfa_pkg::*;
#(
    parameter int APB_AW = 8
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [APB_AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Flag update from the execution unit
    input wire logic upd_valid,
    input wire cfa_alu_op_t upd_op,
    input wire logic [15:0] upd_a,
    input wire logic [7:0] upd_b,
    output logic [15:0] upd_result,
    output logic [7:0] condition_flags,
    // Interrupt gating
    input wire logic irq_req,
    input wire logic instr_boundary,
    input wire logic irq_stacked,
    output logic irq_take,
    // Operand command
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire cfa_mode_t cmd_mode,
    input wire cfa_cond_t cmd_cond,
    input wire logic [2:0] cmd_bit,
    input wire logic [7:0] cmd_ref,
    input wire logic [15:0] cmd_dst,
    output logic cmd_done,
    output logic cmd_taken,
    output logic [15:0] operand,
    // Program counter load
    input wire logic pc_load,
    input wire logic [15:0] pc_load_value,
    output logic [15:0] program_counter,
    // Memory bus
    output logic mem_req,
    output logic mem_we,
    output logic [ADDR_W-1:0] mem_addr,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_ack
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (APB_AW < 4 || APB_AW > 16) begin : g_bad_aw
        $error("APB_AW must be 4 to 16");
    end

    typedef enum logic [2:0] {
        S_IDLE, S_FETCH_HI, S_FETCH_LO, S_FETCH_OFFS, S_STORE
    } cfa_state_t;

    cfa_state_t state_ff;
    cfa_state_t nxt_state;
    logic [7:0] flags_ff;
    logic [7:0] nxt_flags;
    logic [15:0] pc_ff;
    logic [15:0] operand_ff;
    logic [15:0] dst_ff;
    logic [15:0] result_ff;
    logic inhibit_ff;
    logic done_ff;
    logic taken_ff;
    cfa_mode_t mode_ff;
    cfa_cond_t cond_ff;
    logic [2:0] bit_ff;
    logic [7:0] ref_ff;
    logic [15:0] alu_res;
    logic [7:0] alu_flags;
    logic [7:0] alu_affect;
    logic apb_wr;
    logic apb_rd;
    logic cond_ok;
    logic bit_val;
    logic fetch_ack;
    logic [15:0] pc_next_seq;
    logic [15:0] offs_ext;

    // ------------------------------------------------------------
    // Flag arithmetic
    // ------------------------------------------------------------
    cfa_alu u_alu (
        .op(upd_op),
        .a(upd_a),
        .b(upd_b),
        .flags_in(flags_ff),
        .res(alu_res),
        .flag_val(alu_flags),
        .affect(alu_affect)
    );

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && !pwrite;
    assign pready = 1'b1;

    always_comb begin
        pslverr = 1'b0;
        if (psel && penable) begin
            if (paddr == APB_AW'(REG_FLAGS)) begin
                pslverr = 1'b0;
            end else if (paddr == APB_AW'(REG_PC)) begin
                pslverr = 1'b0;
            end else if (paddr == APB_AW'(REG_STATUS)) begin
                pslverr = 1'b0;
            end else if (paddr == APB_AW'(REG_OPERAND)) begin
                pslverr = 1'b0;
            end else begin
                pslverr = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (apb_rd && !penable) begin
            if (paddr == APB_AW'(REG_FLAGS)) begin
                prdata <= {24'h00_0000, flags_ff};
            end else if (paddr == APB_AW'(REG_PC)) begin
                prdata <= {16'h0000, pc_ff};
            end else if (paddr == APB_AW'(REG_STATUS)) begin
                prdata <= {27'h000_0000, inhibit_ff, 1'b0, state_ff};
            end else if (paddr == APB_AW'(REG_OPERAND)) begin
                prdata <= {16'h0000, operand_ff};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------
    // Condition evaluation
    // ------------------------------------------------------------
    assign bit_val = operand_ff[bit_ff];

    always_comb begin
        case (cond_ff)
            COND_ALWAYS: cond_ok = 1'b1;
            COND_SGT: cond_ok = !(flags_ff[FLAG_Z] ||
                (flags_ff[FLAG_N] ^ flags_ff[FLAG_V]));
            COND_SGE: cond_ok = !(flags_ff[FLAG_N] ^ flags_ff[FLAG_V]);
            COND_SLE: cond_ok = flags_ff[FLAG_Z] ||
                (flags_ff[FLAG_N] ^ flags_ff[FLAG_V]);
            COND_SLT: cond_ok = flags_ff[FLAG_N] ^ flags_ff[FLAG_V];
            COND_BIT_HIGH: cond_ok = bit_val;
            COND_BIT_LOW: cond_ok = !bit_val;
            COND_CMP_EQ: cond_ok = (operand_ff[7:0] == ref_ff);
            COND_DEC_NZ: cond_ok = (operand_ff[7:0] != 8'h01);
            default: cond_ok = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Flag register
    // ------------------------------------------------------------
    always_comb begin
        nxt_flags = flags_ff;
        if (upd_valid) begin
            nxt_flags = (flags_ff & ~alu_affect) | (alu_flags & alu_affect);
            if (upd_op == ALU_MASK_CLEAR) begin
                nxt_flags[FLAG_I] = 1'b0;
            end else if (upd_op == ALU_MASK_SET) begin
                nxt_flags[FLAG_I] = 1'b1;
            end
        end
        if (state_ff == S_FETCH_OFFS && mem_ack &&
            (cond_ff == COND_BIT_HIGH || cond_ff == COND_BIT_LOW)) begin
            nxt_flags[FLAG_C] = bit_val;
        end
        if (apb_wr && paddr == APB_AW'(REG_FLAGS)) begin
            nxt_flags = pwdata[7:0];
        end
        if (irq_stacked) begin
            nxt_flags[FLAG_I] = 1'b1;
        end
        nxt_flags = nxt_flags | FLAGS_FIXED_ONES;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_ff <= FLAGS_RESET;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_ff <= 16'h0000;
        end else if (upd_valid) begin
            result_ff <= alu_res;
        end
    end

    // ------------------------------------------------------------
    // Interrupt gating
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            inhibit_ff <= 1'b0;
        end else if (flags_ff[FLAG_I] && !nxt_flags[FLAG_I]) begin
            inhibit_ff <= 1'b1;
        end else if (instr_boundary) begin
            inhibit_ff <= 1'b0;
        end
    end

    assign irq_take = instr_boundary && irq_req && !flags_ff[FLAG_I] && !inhibit_ff;

    // ------------------------------------------------------------
    // Operand sequencer
    // ------------------------------------------------------------
    assign cmd_ready = (state_ff == S_IDLE);
    assign fetch_ack = mem_ack && (state_ff == S_FETCH_HI ||
        state_ff == S_FETCH_LO || state_ff == S_FETCH_OFFS);
    assign pc_next_seq = pc_ff + 16'h0001;
    assign offs_ext = {{8{mem_rdata[7]}}, mem_rdata};

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            S_IDLE: begin
                if (cmd_valid) begin
                    case (cmd_mode)
                        MODE_IMM8, MODE_TEST_IMM, MODE_MOVE: nxt_state = S_FETCH_LO;
                        MODE_IMM16: nxt_state = S_FETCH_HI;
                        MODE_REL, MODE_TEST_REG: nxt_state = S_FETCH_OFFS;
                        default: nxt_state = S_IDLE;
                    endcase
                end
            end
            S_FETCH_HI: begin
                if (mem_ack) begin
                    nxt_state = S_FETCH_LO;
                end
            end
            S_FETCH_LO: begin
                if (mem_ack) begin
                    if (mode_ff == MODE_TEST_IMM) begin
                        nxt_state = S_FETCH_OFFS;
                    end else if (mode_ff == MODE_MOVE) begin
                        nxt_state = S_STORE;
                    end else begin
                        nxt_state = S_IDLE;
                    end
                end
            end
            S_FETCH_OFFS, S_STORE: begin
                if (mem_ack) begin
                    nxt_state = S_IDLE;
                end
            end
            default: nxt_state = S_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= S_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_ff <= MODE_REG;
            cond_ff <= COND_ALWAYS;
            bit_ff <= 3'h0;
            ref_ff <= 8'h00;
            dst_ff <= 16'h0000;
        end else if (cmd_valid && cmd_ready) begin
            mode_ff <= cmd_mode;
            cond_ff <= cmd_cond;
            bit_ff <= cmd_bit;
            ref_ff <= cmd_ref;
            dst_ff <= cmd_dst;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            operand_ff <= 16'h0000;
        end else if (cmd_valid && cmd_ready) begin
            if (cmd_mode == MODE_REG || cmd_mode == MODE_TEST_REG) begin
                operand_ff <= {8'h00, cmd_ref};
            end else begin
                operand_ff <= 16'h0000;
            end
        end else if (state_ff == S_FETCH_HI && mem_ack) begin
            operand_ff[15:8] <= mem_rdata;
        end else if (state_ff == S_FETCH_LO && mem_ack) begin
            operand_ff[7:0] <= mem_rdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_ff <= PC_RESET;
        end else if (pc_load) begin
            pc_ff <= pc_load_value;
        end else if (state_ff == S_FETCH_OFFS && mem_ack && cond_ok) begin
            pc_ff <= pc_next_seq + offs_ext;
        end else if (fetch_ack) begin
            pc_ff <= pc_next_seq;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_ff <= 1'b0;
            taken_ff <= 1'b0;
        end else begin
            done_ff <= (state_ff == S_IDLE && cmd_valid && cmd_mode == MODE_REG) ||
                (state_ff != S_IDLE && nxt_state == S_IDLE);
            taken_ff <= state_ff == S_FETCH_OFFS && mem_ack && cond_ok;
        end
    end

    // ------------------------------------------------------------
    // Memory bus drive
    // ------------------------------------------------------------
    assign mem_req = (state_ff != S_IDLE);
    assign mem_we = (state_ff == S_STORE);
    assign mem_addr = (state_ff == S_STORE) ? dst_ff : pc_ff;
    assign mem_wdata = operand_ff[7:0];

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign condition_flags = flags_ff;
    assign program_counter = pc_ff;
    assign operand = operand_ff;
    assign upd_result = result_ff;
    assign cmd_done = done_ff;
    assign cmd_taken = taken_ff;

endmodule

// File: hw/cfa_pkg.sv
package cfa_pkg;

    // ------------------------------------------------------------
    // Flag register layout
    // ------------------------------------------------------------
    localparam int FLAG_W = 8;
    localparam int FLAG_V = 7;
    localparam int FLAG_H = 4;
    localparam int FLAG_I = 3;
    localparam int FLAG_N = 2;
    localparam int FLAG_Z = 1;
    localparam int FLAG_C = 0;
    localparam logic [7:0] FLAGS_FIXED_ONES = 8'h60;
    localparam logic [7:0] FLAGS_RESET = 8'h68;

    // ------------------------------------------------------------
    // Address space and program counter
    // ------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam logic [15:0] PC_RESET = 16'h0000;

    // ------------------------------------------------------------
    // APB register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_FLAGS = 8'h00;
    localparam logic [7:0] REG_PC = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_OPERAND = 8'h0C;

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_LOGIC, ALU_LOAD8, ALU_LOAD16,
        ALU_SHL, ALU_SHR, ALU_DAA, ALU_MASK_CLEAR, ALU_MASK_SET
    } cfa_alu_op_t;

    typedef enum logic [2:0] {
        MODE_REG, MODE_IMM8, MODE_IMM16, MODE_REL, MODE_TEST_IMM, MODE_TEST_REG,
        MODE_MOVE
    } cfa_mode_t;

    typedef enum logic [3:0] {
        COND_ALWAYS, COND_SGT, COND_SGE, COND_SLE, COND_SLT, COND_BIT_HIGH,
        COND_BIT_LOW, COND_CMP_EQ, COND_DEC_NZ
    } cfa_cond_t;

endpackage

// File: hw/cfa_alu.sv
`timescale 1ns/100ps
module cfa_alu
    import cfa_pkg::*;
(
    // Operation
    input wire cfa_alu_op_t op,
    input wire logic [15:0] a,
    input wire logic [7:0] b,
    input wire logic [7:0] flags_in,
    // Result
    output logic [15:0] res,
    output logic [7:0] flag_val,
    output logic [7:0] affect
);

    logic [8:0] sum9;
    logic [4:0] half5;
    logic [8:0] dif9;
    logic [7:0] corr;
    logic cin;
    logic daa_hi;

    always_comb begin
        cin = 1'b0;
        if (op == ALU_ADC || op == ALU_SBC) begin
            cin = flags_in[FLAG_C];
        end
        sum9 = {1'b0, a[7:0]} + {1'b0, b} + {8'h00, cin};
        half5 = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        dif9 = {1'b0, a[7:0]} - {1'b0, b} - {8'h00, cin};
        daa_hi = flags_in[FLAG_C] || (a[7:0] > 8'h99);
        corr = 8'h00;
        if (flags_in[FLAG_H] || (a[3:0] > 4'h9)) begin
            corr[3:0] = 4'h6;
        end
        if (daa_hi) begin
            corr[7:4] = 4'h6;
        end
        res = {8'h00, a[7:0]};
        flag_val = flags_in;
        affect = 8'h00;
        case (op)
            ALU_ADD, ALU_ADC: begin
                res = {8'h00, sum9[7:0]};
                flag_val[FLAG_H] = half5[4];
                flag_val[FLAG_C] = sum9[8];
                flag_val[FLAG_V] = (a[7] == b[7]) && (sum9[7] != a[7]);
                affect = 8'h97;
            end
            ALU_SUB, ALU_SBC: begin
                res = {8'h00, dif9[7:0]};
                flag_val[FLAG_C] = dif9[8];
                flag_val[FLAG_V] = (a[7] != b[7]) && (dif9[7] != a[7]);
                affect = 8'h87;
            end
            ALU_LOGIC, ALU_LOAD8: begin
                flag_val[FLAG_V] = 1'b0;
                affect = 8'h86;
            end
            ALU_LOAD16: begin
                res = a;
                flag_val[FLAG_V] = 1'b0;
                affect = 8'h86;
            end
            ALU_SHL: begin
                res = {8'h00, a[6:0], 1'b0};
                flag_val[FLAG_C] = a[7];
                flag_val[FLAG_V] = a[6] ^ a[7];
                affect = 8'h87;
            end
            ALU_SHR: begin
                res = {9'h000, a[7:1]};
                flag_val[FLAG_C] = a[0];
                flag_val[FLAG_V] = a[0];
                affect = 8'h87;
            end
            ALU_DAA: begin
                res = {8'h00, a[7:0] + corr};
                flag_val[FLAG_C] = daa_hi;
                affect = 8'h07;
            end
            default: begin
                affect = 8'h00;
            end
        endcase
        if (op == ALU_LOAD16) begin
            flag_val[FLAG_N] = res[15];
            flag_val[FLAG_Z] = (res == 16'h0000);
        end else begin
            flag_val[FLAG_N] = res[7];
            flag_val[FLAG_Z] = (res[7:0] == 8'h00);
        end
    end

endmodule

// File: verif/cfa_mem_model.sv
`timescale 1ns/100ps
module cfa_mem_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Memory bus
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata,
    output logic mem_ack,
    // Wait cycles before each answer
    input wire logic [3:0] lat
);
    logic [7:0] mem [0:65535];
    logic [3:0] cnt_ff;
    logic ack_ff;
    logic [7:0] rd_ff;

    assign mem_ack = ack_ff;
    assign mem_rdata = rd_ff;

    // Read data toggles between answers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 4'h0;
            ack_ff <= 1'b0;
            rd_ff <= 8'h00;
        end else begin
            ack_ff <= 1'b0;
            rd_ff <= ~rd_ff;
            if (mem_req && !ack_ff) begin
                if (cnt_ff >= lat) begin
                    ack_ff <= 1'b1;
                    cnt_ff <= 4'h0;
                    if (mem_we) begin
                        mem[mem_addr] <= mem_wdata;
                    end else begin
                        rd_ff <= mem[mem_addr];
                    end
                end else begin
                    cnt_ff <= cnt_ff + 4'h1;
                end
            end
        end
    end
endmodule

// File: verif/cfa_core_properties.sv
`timescale 1ns/100ps
module cfa_core_properties
    import cfa_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    // Flags and interrupts
    input wire logic upd_valid,
    input wire cfa_alu_op_t upd_op,
    input wire logic [15:0] upd_a,
    input wire logic [7:0] upd_b,
    input wire logic [7:0] condition_flags,
    input wire logic irq_stacked,
    input wire logic irq_take,
    input wire logic instr_boundary,
    // Sequencer
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire cfa_mode_t cmd_mode,
    input wire logic cmd_done,
    input wire logic mem_req
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Update with no bus write or interrupt entry
    logic plain, add, add_v, add_c;
    logic [1:0] ld_nz;
    logic [7:0] sum;
    assign plain = upd_valid && !(psel && penable && pwrite) && !irq_stacked;
    assign add = plain && upd_op == ALU_ADD;
    assign {add_c, sum} = {1'b0, upd_a[7:0]} + {1'b0, upd_b};
    assign add_v = upd_a[7] == upd_b[7] && sum[7] != upd_b[7];
    assign ld_nz = {upd_a[7], upd_a[7:0] == 8'h00};
    chk_fixed_ones:
        assert property (condition_flags[6:5] == 2'b11) else $error("fixed bits not one");
    chk_add_overflow:
        assert property (add |=> condition_flags[7] == $past(add_v))
        else $error("overflow flag wrong");
    chk_add_carry:
        assert property (add |=> condition_flags[0] == $past(add_c))
        else $error("carry flag wrong");
    chk_load_flags:
        assert property (plain && upd_op == ALU_LOAD8 |=> condition_flags[2:1]
            == $past(ld_nz)) else $error("load flags wrong");
    chk_mask_blocks:
        assert property (irq_take |-> !condition_flags[3]) else $error("taken while masked");
    chk_stack_mask:
        assert property (irq_stacked |=> condition_flags[3]) else $error("mask not set");
    chk_clear_inhibit:
        assert property ($fell(condition_flags[3]) |-> (!irq_take and
            (instr_boundary or ##1 !irq_take))) else $error("taken right after clear");
    chk_reg_nomem:
        assert property (cmd_valid && cmd_ready && cmd_mode == MODE_REG |=> cmd_done
            && !mem_req) else $error("register mode used memory");
endmodule

bind cfa_core cfa_core_properties u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .upd_valid(upd_valid), .upd_op(upd_op), .upd_a(upd_a), .upd_b(upd_b),
    .condition_flags(condition_flags), .irq_stacked(irq_stacked), .irq_take(irq_take),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_mode(cmd_mode),
    .cmd_done(cmd_done), .mem_req(mem_req), .instr_boundary(instr_boundary)
);

// File: verif/testbench.sv
`timescale 1ns/100ps
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin n_fail++; \
    $display("wrong value %s expected %h seen %h", n, e, a); end end
module testbench
    import cfa_pkg::*;
;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, upd_b = 8'h00, cmd_ref = 8'h00, flags, mem_wdata, mem_rdata;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, tk, irq_take, cmd_ready, cmd_done, cmd_taken;
    logic upd_valid = 1'b0, irq_req = 1'b0, instr_boundary = 1'b0, irq_stacked = 1'b0;
    logic cmd_valid = 1'b0, pc_load = 1'b0, mem_req, mem_we, mem_ack;
    logic [15:0] upd_a = 16'h0, cmd_dst = 16'h0, pc_load_value = 16'h0;
    logic [15:0] upd_result, operand, pc, mem_addr;
    logic [2:0] cmd_bit = 3'h0;
    logic [3:0] lat = 4'h2;
    cfa_alu_op_t upd_op = ALU_ADD;
    cfa_mode_t cmd_mode = MODE_REG;
    cfa_cond_t cmd_cond = COND_ALWAYS;
    int n_fail = 0, comparisons = 0, cyc = 0;
    cfa_alu_op_t t_op [9] = '{ALU_ADD, ALU_ADD, ALU_ADC, ALU_SUB, ALU_LOAD8, ALU_LOAD16,
        ALU_ADD, ALU_DAA, ALU_SHL};
    logic [15:0] t_a [9] = '{16'h7F, 16'hFF, 16'h0F, 16'h0, 16'h0, 16'h8000, 16'h15, 16'h3C,
        16'h81};
    logic [7:0] t_b [9] = '{8'h1, 8'h1, 8'h0, 8'h1, 8'h0, 8'h0, 8'h27, 8'h0, 8'h0};
    logic [7:0] t_f [9] = '{8'hF4, 8'h73, 8'h70, 8'h75, 8'h02, 8'h04, 8'h60, 8'h00, 8'h01};
    logic [7:0] t_m [9] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h06, 8'h06, 8'hFF, 8'h07, 8'h07};
    logic [7:0] t_r [9] = '{8'h80, 8'h00, 8'h10, 8'hFF, 8'h00, 8'h00, 8'h3C, 8'h42, 8'h02};

    always #2.5 pclk = ~pclk;

    cfa_core dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .upd_valid(upd_valid), .upd_op(upd_op),
        .upd_a(upd_a), .upd_b(upd_b), .upd_result(upd_result), .condition_flags(flags),
        .irq_req(irq_req), .instr_boundary(instr_boundary), .irq_stacked(irq_stacked),
        .irq_take(irq_take), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_mode(cmd_mode), .cmd_cond(cmd_cond), .cmd_bit(cmd_bit), .cmd_ref(cmd_ref),
        .cmd_dst(cmd_dst), .cmd_done(cmd_done), .cmd_taken(cmd_taken), .operand(operand),
        .pc_load(pc_load), .pc_load_value(pc_load_value), .program_counter(pc),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack));
    cfa_mem_model mm (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .mem_ack(mem_ack), .lat(lat));

    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic end_of_test;
        if (n_fail == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            end_of_test();
        end
    end

    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic upd(input cfa_alu_op_t o, input logic [15:0] a, input logic [7:0] b);
        @(posedge pclk);
        upd_valid <= 1'b1;
        upd_op <= o;
        upd_a <= a;
        upd_b <= b;
        @(posedge pclk);
        upd_valid <= 1'b0;
        #1;
    endtask

    task automatic bnd;
        @(posedge pclk);
        instr_boundary <= 1'b1;
        #1;
        tk = irq_take;
        @(posedge pclk);
        instr_boundary <= 1'b0;
    endtask

    task automatic cmd(input cfa_mode_t m, input cfa_cond_t c, input logic [2:0] b,
            input logic [7:0] r, input logic [15:0] d);
        @(posedge pclk);
        cmd_valid <= 1'b1;
        cmd_mode <= m;
        cmd_cond <= c;
        cmd_bit <= b;
        cmd_ref <= r;
        cmd_dst <= d;
        do @(posedge pclk); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
        do @(posedge pclk); while (cmd_done !== 1'b1);
        tk = cmd_taken;
        #1;
    endtask

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        mm.mem[16'h0010] = 8'hAB;
        mm.mem[16'h0011] = 8'h03;
        mm.mem[16'h0012] = 8'hFE;
        mm.mem[16'h0015] = 8'h77;
        mm.mem[16'hFFFF] = 8'h02;
        mm.mem[16'h0002] = 8'h01;
        mm.mem[16'h0003] = 8'h10;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, REG_FLAGS, 32'h0);
        `CHK("flags reset", 32'h68, rd)
        apb(1'b1, REG_FLAGS, 32'h0);
        apb(1'b0, REG_FLAGS, 32'h0);
        `CHK("fixed ones", 32'h60, rd)
        apb(1'b0, 8'h10, 32'h0);
        `CHK("unmapped", 33'h100000000, {er, rd})
        for (int i = 0; i < 9; i++) begin
            upd(t_op[i], t_a[i], t_b[i]);
            `CHK("flags", t_f[i] & t_m[i], flags & t_m[i])
            `CHK("result", t_r[i], upd_result[7:0])
        end
        apb(1'b1, REG_FLAGS, 32'h08);
        irq_req <= 1'b1;
        bnd();
        `CHK("masked take", 1'b0, tk)
        upd(ALU_MASK_CLEAR, 16'h0, 8'h0);
        `CHK("clear keeps", 8'h60, flags)
        bnd();
        `CHK("inhibit take", 1'b0, tk)
        bnd();
        `CHK("open take", 1'b1, tk)
        irq_req <= 1'b0;
        irq_stacked <= 1'b1;
        @(posedge pclk);
        irq_stacked <= 1'b0;
        pc_load <= 1'b1;
        pc_load_value <= 16'h0010;
        #1;
        `CHK("stack mask", 8'h68, flags)
        @(posedge pclk);
        pc_load <= 1'b0;
        cmd(MODE_IMM16, COND_ALWAYS, 3'h0, 8'h00, 16'h0);
        `CHK("imm16", 16'hAB03, operand)
        `CHK("pc step", 16'h0012, pc)
        lat <= 4'h0;
        cmd(MODE_REL, COND_SGT, 3'h0, 8'h00, 16'h0);
        `CHK("rel pc", 17'h10011, {tk, pc})
        cmd(MODE_REG, COND_ALWAYS, 3'h0, 8'h5A, 16'h0);
        `CHK("reg operand", 24'h5A0011, {operand[7:0], pc})
        cmd(MODE_TEST_REG, COND_BIT_HIGH, 3'h2, 8'h04, 16'h0);
        `CHK("test", 18'h30015, {tk, flags[FLAG_C], pc})
        cmd(MODE_MOVE, COND_ALWAYS, 3'h0, 8'h00, 16'h1234);
        `CHK("move", 24'h770016, {mm.mem[16'h1234], pc})
        @(posedge pclk);
        pc_load <= 1'b1;
        pc_load_value <= 16'hFFFF;
        @(posedge pclk);
        pc_load <= 1'b0;
        cmd(MODE_REL, COND_SGE, 3'h0, 8'h00, 16'h0);
        `CHK("rel wrap", 16'h0002, pc)
        cmd(MODE_TEST_IMM, COND_BIT_LOW, 3'h0, 8'h00, 16'h0);
        `CHK("not taken", 18'h10004, {tk, flags[FLAG_C], pc})
        end_of_test();
    end
endmodule
